// ==== hdl/nasu_core.sv ====
// Purpose: execution datapath and skip decision of a 4-bit controller core
// Assumes: one instruction issued per cycle while not busy; memory nibble
//   at the data pointer and table pattern arrive synchronous to clk_i
// Notes: the table pattern is sampled one cycle after the table request
//
// Functional notes
// RQ1: Immediate load; consecutive loads after first skipped
// RQ2: Table pattern high nibble to B, low to accumulator
// RQ3: Table address is extension bits then accumulator
// RQ4: Upper fetch copies bits 9,8; clears extension bit2
// RQ5: Table lookup occupies one return stack level
// RQ6: Memory add into accumulator, carry untouched
// RQ7: Memory plus carry add, carry takes carry-out
// RQ8: Immediate add, carry untouched, skip without overflow
// RQ9: Accumulator becomes accumulator AND memory nibble
// RQ10: Accumulator becomes accumulator OR memory nibble
// RQ11: Set or clear carry, nothing else changes
// RQ12: Skip next instruction when carry is zero
// RQ13: Accumulator becomes its bitwise inverse
// RQ14: Rotate carry and accumulator right by one
// RQ15: Set or clear selected bit of memory nibble
// RQ16: Skip when selected memory bit is zero
// RQ17: Skip when accumulator equals memory nibble
// RQ18: Skip when accumulator equals immediate value
// RQ19: Skipped instruction changes no state at all; here it clears the skip flag and sets load_chain only if it is a load
// RQ20: Four-bit values, wrap at sixteen, overflow is carry
`default_nettype none

module nasu_core #(
    parameter int DATA_W = nasu_pkg::DATA_W,
    parameter int ROM_W = nasu_pkg::ROM_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire nasu_pkg::nasu_issue_t issue_i,
    output logic busy_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output nasu_pkg::nasu_mem_wr_t mem_wr_o,
    output nasu_pkg::nasu_rom_req_t rom_req_o,
    input wire logic [ROM_W-1:0] rom_data_i,
    output logic stack_use_o,
    output logic skip_o,
    output logic [DATA_W-1:0] acc_o,
    output logic [DATA_W-1:0] b_reg_o,
    output logic [nasu_pkg::EXT_W-1:0] ext_reg_o,
    output logic carry_o,
    input wire nasu_pkg::nasu_reg_req_t reg_req_i,
    output logic [nasu_pkg::REG_DW-1:0] reg_rdata_o
);

    typedef struct packed {
        nasu_pkg::nasu_phase_t phase;
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] b_reg;
        logic [nasu_pkg::EXT_W-1:0] ext;
        logic carry;
        logic skip;
        logic load_chain;
        logic upper_table_fetch_flag;
        nasu_pkg::nasu_mem_wr_t mem_wr;
        nasu_pkg::nasu_rom_req_t rom_req;
        logic stack_use;
        logic [nasu_pkg::REG_DW-1:0] rdata;
    } nasu_state_t;

    localparam nasu_state_t STATE_RESET = '{
        phase: nasu_pkg::NASU_IDLE,
        acc: nasu_pkg::ACC_RESET,
        b_reg: nasu_pkg::B_RESET,
        ext: nasu_pkg::EXT_RESET,
        carry: nasu_pkg::CARRY_RESET,
        skip: 1'h0,
        load_chain: 1'h0,
        upper_table_fetch_flag: nasu_pkg::CTRL_UPPER_TABLE_FETCH_FLAG_RESET,
        mem_wr: '0,
        rom_req: '0,
        stack_use: 1'h0,
        rdata: '0
    };

    // Sum of two nibbles and a carry-in; bit 4 is the overflow
    function automatic logic [DATA_W:0] nibble_add(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic cin
    );
        nibble_add = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    endfunction

    // One-hot mask of the bit picked by the 2-bit immediate field
    function automatic logic [DATA_W-1:0] bit_mask(
        input logic [1:0] sel
    );
        bit_mask = DATA_W'(1) << sel;
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    nasu_state_t state;
    nasu_state_t next_state;
    logic take;
    logic [DATA_W:0] sum;

    // Release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // New instructions wait while a table pattern is outstanding
    assign take = issue_i.valid && (state.phase == nasu_pkg::NASU_IDLE);

    always_comb begin
        next_state = state;
        next_state.mem_wr.we = 1'b0;
        next_state.rom_req.req = 1'b0;
        sum = '0;

        unique case (state.phase)
            nasu_pkg::NASU_IDLE: begin
                if (take) begin
                    if (state.skip) begin
                        // Fetched but dropped; chain only tracks loads
                        next_state.skip = 1'b0; // RQ19
                        next_state.load_chain =
                            (issue_i.op == nasu_pkg::NASU_LOAD_ACC_IMMEDIATE);
                    end else begin
                        next_state.skip = 1'b0;
                        next_state.load_chain = 1'b0;
                        unique case (issue_i.op)
                            nasu_pkg::NASU_NOP: begin
                            end
                            nasu_pkg::NASU_LOAD_ACC_IMMEDIATE: begin
                                next_state.load_chain = 1'b1; // RQ1
                                if (!state.load_chain) begin
                                    next_state.acc = issue_i.imm; // RQ1
                                end
                            end
                            nasu_pkg::NASU_TABLE_LOOKUP: begin
                                next_state.phase = nasu_pkg::NASU_TABLE_WAIT;
                                next_state.rom_req.req = 1'b1;
                                next_state.rom_req.page = issue_i.page;
                                next_state.rom_req.addr =
                                    {state.ext, state.acc}; // RQ3
                                next_state.stack_use = 1'b1; // RQ5
                            end
                            nasu_pkg::NASU_ADD_MEMORY: begin
                                sum = nibble_add(state.acc, mem_rdata_i,
                                    1'b0);
                                next_state.acc = sum[DATA_W-1:0]; // RQ6
                            end
                            nasu_pkg::NASU_ADD_MEMORY_CARRY: begin
                                sum = nibble_add(state.acc, mem_rdata_i,
                                    state.carry);
                                next_state.acc = sum[DATA_W-1:0]; // RQ7
                                next_state.carry = sum[DATA_W]; // RQ20
                            end
                            nasu_pkg::NASU_ADD_IMMEDIATE: begin
                                sum = nibble_add(state.acc, issue_i.imm,
                                    1'b0);
                                next_state.acc = sum[DATA_W-1:0];
                                next_state.skip = !sum[DATA_W]; // RQ8
                            end
                            nasu_pkg::NASU_AND_MEMORY: begin
                                next_state.acc =
                                    state.acc & mem_rdata_i; // RQ9
                            end
                            nasu_pkg::NASU_OR_MEMORY: begin
                                next_state.acc =
                                    state.acc | mem_rdata_i; // RQ10
                            end
                            nasu_pkg::NASU_SET_CARRY: begin
                                next_state.carry = 1'b1; // RQ11
                            end
                            nasu_pkg::NASU_CLEAR_CARRY: begin
                                next_state.carry = 1'b0; // RQ11
                            end
                            nasu_pkg::NASU_SKIP_CARRY_ZERO: begin
                                next_state.skip = !state.carry; // RQ12
                            end
                            nasu_pkg::NASU_COMPLEMENT_ACC: begin
                                next_state.acc = ~state.acc; // RQ13
                            end
                            nasu_pkg::NASU_ROTATE_RIGHT_CARRY: begin
                                next_state.acc =
                                    {state.carry,
                                    state.acc[DATA_W-1:1]}; // RQ14
                                next_state.carry = state.acc[0]; // RQ14
                            end
                            nasu_pkg::NASU_MEMORY_BIT_SET: begin
                                next_state.mem_wr.we = 1'b1;
                                next_state.mem_wr.wdata = mem_rdata_i |
                                    bit_mask(issue_i.imm[1:0]); // RQ15
                            end
                            nasu_pkg::NASU_MEMORY_BIT_CLEAR: begin
                                next_state.mem_wr.we = 1'b1;
                                next_state.mem_wr.wdata = mem_rdata_i &
                                    ~bit_mask(issue_i.imm[1:0]); // RQ15
                            end
                            nasu_pkg::NASU_MEMORY_BIT_TEST: begin
                                next_state.skip = (mem_rdata_i &
                                    bit_mask(issue_i.imm[1:0])) ==
                                    '0; // RQ16
                            end
                            nasu_pkg::NASU_COMPARE_MEMORY: begin
                                next_state.skip =
                                    (state.acc == mem_rdata_i); // RQ17
                            end
                            nasu_pkg::NASU_COMPARE_IMMEDIATE: begin
                                next_state.skip =
                                    (state.acc == issue_i.imm); // RQ18
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            nasu_pkg::NASU_TABLE_WAIT: begin
                // Pattern is valid in the cycle after the request
                next_state.phase = nasu_pkg::NASU_IDLE;
                next_state.stack_use = 1'b0; // RQ5
                next_state.b_reg =
                    rom_data_i[nasu_pkg::ROM_B_LSB +: DATA_W]; // RQ2
                next_state.acc =
                    rom_data_i[nasu_pkg::ROM_A_LSB +: DATA_W]; // RQ2
                if (state.upper_table_fetch_flag) begin
                    next_state.ext = {1'b0,
                        rom_data_i[nasu_pkg::ROM_EXT_LSB +: 2]}; // RQ4
                end
            end
        endcase

        // Register port; setup preset loses to an instruction result
        next_state.rdata = '0;
        if (reg_req_i.re) begin
            unique case (reg_req_i.addr)
                nasu_pkg::CTRL_OFFSET: begin
                    next_state.rdata[nasu_pkg::CTRL_UPPER_TABLE_FETCH_FLAG_BIT] =
                        state.upper_table_fetch_flag;
                end
                nasu_pkg::STATUS_OFFSET: begin
                    next_state.rdata[nasu_pkg::STAT_ACC_LSB +: DATA_W] =
                        state.acc;
                    next_state.rdata[nasu_pkg::STAT_B_LSB +: DATA_W] =
                        state.b_reg;
                    next_state.rdata[nasu_pkg::STAT_EXT_LSB +:
                        nasu_pkg::EXT_W] = state.ext;
                    next_state.rdata[nasu_pkg::STAT_CARRY_BIT] = state.carry;
                    next_state.rdata[nasu_pkg::STAT_SKIP_BIT] = state.skip;
                    next_state.rdata[nasu_pkg::STAT_BUSY_BIT] =
                        (state.phase != nasu_pkg::NASU_IDLE);
                    next_state.rdata[nasu_pkg::STAT_CHAIN_BIT] =
                        state.load_chain;
                end
                default: begin
                end
            endcase
        end
        if (reg_req_i.we) begin
            if (reg_req_i.addr == nasu_pkg::CTRL_OFFSET) begin
                next_state.upper_table_fetch_flag =
                    reg_req_i.wdata[nasu_pkg::CTRL_UPPER_TABLE_FETCH_FLAG_BIT];
            end
            if (reg_req_i.addr == nasu_pkg::SETUP_OFFSET && !take &&
                state.phase == nasu_pkg::NASU_IDLE) begin
                next_state.acc =
                    reg_req_i.wdata[nasu_pkg::SETUP_ACC_LSB +: DATA_W];
                next_state.b_reg =
                    reg_req_i.wdata[nasu_pkg::SETUP_B_LSB +: DATA_W];
                next_state.ext = reg_req_i.wdata[nasu_pkg::SETUP_EXT_LSB +:
                    nasu_pkg::EXT_W];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign busy_o = (state.phase != nasu_pkg::NASU_IDLE);
    assign mem_wr_o = state.mem_wr;
    assign rom_req_o = state.rom_req;
    assign stack_use_o = state.stack_use;
    assign skip_o = state.skip;
    assign acc_o = state.acc;
    assign b_reg_o = state.b_reg;
    assign ext_reg_o = state.ext;
    assign carry_o = state.carry;
    assign reg_rdata_o = state.rdata;

endmodule

`default_nettype wire

// ==== hdl/nasu_pkg.sv ====
// Purpose: shared types and constants of the nibble ALU and skip unit
// Assumes: 4-bit data path, 10-bit program memory words
// Notes: register port offsets are byte addresses of 32-bit words
`default_nettype none

package nasu_pkg;

    localparam int DATA_W = 4;
    localparam int ROM_W = 10;
    localparam int EXT_W = 3;
    localparam int PAGE_W = 5;
    localparam int INPAGE_W = 7;
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;

    // Register port map
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] SETUP_OFFSET = 4'h8;
    localparam int CTRL_UPPER_TABLE_FETCH_FLAG_BIT = 0;
    localparam logic CTRL_UPPER_TABLE_FETCH_FLAG_RESET = 1'h0;

    // Status word field positions
    localparam int STAT_ACC_LSB = 0;
    localparam int STAT_B_LSB = 4;
    localparam int STAT_EXT_LSB = 8;
    localparam int STAT_CARRY_BIT = 12;
    localparam int STAT_SKIP_BIT = 13;
    localparam int STAT_BUSY_BIT = 14;
    localparam int STAT_CHAIN_BIT = 15;

    // Setup word: preset of accumulator, B and extension register
    localparam int SETUP_ACC_LSB = 0;
    localparam int SETUP_B_LSB = 4;
    localparam int SETUP_EXT_LSB = 8;

    // Table pattern fields
    localparam int ROM_A_LSB = 0;
    localparam int ROM_B_LSB = 4;
    localparam int ROM_EXT_LSB = 8;

    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [3:0] B_RESET = 4'h0;
    localparam logic [2:0] EXT_RESET = 3'h0;
    localparam logic CARRY_RESET = 1'h0;

    typedef enum logic [4:0] {
        NASU_NOP,
        NASU_LOAD_ACC_IMMEDIATE,
        NASU_TABLE_LOOKUP,
        NASU_ADD_MEMORY,
        NASU_ADD_MEMORY_CARRY,
        NASU_ADD_IMMEDIATE,
        NASU_AND_MEMORY,
        NASU_OR_MEMORY,
        NASU_SET_CARRY,
        NASU_CLEAR_CARRY,
        NASU_SKIP_CARRY_ZERO,
        NASU_COMPLEMENT_ACC,
        NASU_ROTATE_RIGHT_CARRY,
        NASU_MEMORY_BIT_SET,
        NASU_MEMORY_BIT_CLEAR,
        NASU_MEMORY_BIT_TEST,
        NASU_COMPARE_MEMORY,
        NASU_COMPARE_IMMEDIATE
    } nasu_op_t;

    typedef enum logic [0:0] {
        NASU_IDLE,
        NASU_TABLE_WAIT
    } nasu_phase_t;

    typedef struct packed {
        logic valid;
        nasu_op_t op;
        logic [DATA_W-1:0] imm;
        logic [PAGE_W-1:0] page;
    } nasu_issue_t;

    typedef struct packed {
        logic we;
        logic [DATA_W-1:0] wdata;
    } nasu_mem_wr_t;

    typedef struct packed {
        logic req;
        logic [PAGE_W-1:0] page;
        logic [INPAGE_W-1:0] addr;
    } nasu_rom_req_t;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wdata;
        logic we;
        logic re;
    } nasu_reg_req_t;

endpackage

`default_nettype wire

// ==== verif/nasu_core_monitor.sv ====
// Purpose: port checks of the nibble ALU and skip unit
// Assumes: one clock domain; resetn_i low disables every check
// Notes: the load chain is internal, so loads are left to the bench
`default_nettype none
module nasu_monitor #(
    parameter int DATA_W = 4,
    parameter int ROM_W = 10
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire nasu_pkg::nasu_issue_t issue_i,
    input wire logic busy_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire nasu_pkg::nasu_mem_wr_t mem_wr_o,
    input wire nasu_pkg::nasu_rom_req_t rom_req_o,
    input wire logic [ROM_W-1:0] rom_data_i,
    input wire logic stack_use_o,
    input wire logic skip_o,
    input wire logic [DATA_W-1:0] acc_o,
    input wire logic [DATA_W-1:0] b_reg_o,
    input wire logic [nasu_pkg::EXT_W-1:0] ext_reg_o,
    input wire logic carry_o,
    input wire nasu_pkg::nasu_reg_req_t reg_req_i,
    input wire logic [nasu_pkg::REG_DW-1:0] reg_rdata_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic run;
    // Executed, not skipped and not refused
    assign run = issue_i.valid && !busy_o && !skip_o;

    a_stack_held: assert property (busy_o |-> stack_use_o)
        else $error("stack level not held in table wait");
    a_table_addr: assert property (rom_req_o.req |->
        rom_req_o.addr == {ext_reg_o, acc_o}) else $error("bad table address");
    a_table_load: assert property (rom_req_o.req |=>
        acc_o == $past(rom_data_i[3:0]) && b_reg_o == $past(rom_data_i[7:4]))
        else $error("table pattern not loaded");
    a_acc_invert: assert property (run &&
        issue_i.op == nasu_pkg::NASU_COMPLEMENT_ACC |=> acc_o == ~$past(acc_o))
        else $error("complement wrong");
    a_carry_set: assert property (run &&
        issue_i.op == nasu_pkg::NASU_SET_CARRY |=> carry_o && $stable(acc_o))
        else $error("set carry wrong");
    a_carry_skip: assert property (run &&
        issue_i.op == nasu_pkg::NASU_SKIP_CARRY_ZERO |=>
        skip_o == !$past(carry_o)) else $error("carry skip wrong");
    a_imm_compare: assert property (run &&
        issue_i.op == nasu_pkg::NASU_COMPARE_IMMEDIATE |=>
        skip_o == ($past(acc_o) == $past(issue_i.imm)))
        else $error("immediate compare wrong");
    a_bit_clear: assert property (run &&
        issue_i.op == nasu_pkg::NASU_MEMORY_BIT_CLEAR |=> mem_wr_o.we &&
        mem_wr_o.wdata == ($past(mem_rdata_i) &
        ~(4'h1 << $past(issue_i.imm[1:0]))))
        else $error("bit clear wrong");
    a_skip_quiet: assert property (issue_i.valid && !busy_o &&
        skip_o |=> !mem_wr_o.we && !rom_req_o.req && !skip_o &&
        $stable(acc_o) && $stable(carry_o) && $stable(b_reg_o))
        else $error("skipped instruction changed state");
endmodule

bind nasu_core nasu_monitor #(.DATA_W(DATA_W), .ROM_W(ROM_W)) mon_u (.*);
`default_nettype wire

// ==== verif/test_nibble_alu_skip_unit.sv ====
// Purpose: directed bench for the nibble ALU and skip unit
// Assumes: table pattern answered one cycle after the request
// Notes: setup preset stands in for program flow between operations
`default_nettype none
module test_nibble_alu_skip_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    nasu_pkg::nasu_issue_t issue_i = '0;
    logic [3:0] mem_rdata_i = 4'h0;
    logic [9:0] rom_data_i = 10'h000;
    nasu_pkg::nasu_reg_req_t reg_req_i = '0;
    nasu_pkg::nasu_mem_wr_t mem_wr_o;
    nasu_pkg::nasu_rom_req_t rom_req_o;
    logic busy_o, stack_use_o, skip_o, carry_o;
    logic [3:0] acc_o, b_reg_o;
    logic [2:0] ext_reg_o;
    logic [31:0] reg_rdata_o, rd;
    int n_errors = 0;
    int compares = 0;
    always #50 clk_i = ~clk_i;
    nasu_core dut_u (.*);

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic reg_acc(logic we, logic [3:0] a, logic [31:0] d);
        @(posedge clk_i);
        reg_req_i <= '{a, d, we, !we};
        @(posedge clk_i);
        reg_req_i.we <= 1'b0;
        reg_req_i.re <= 1'b0;
        @(negedge clk_i);
        rd = reg_rdata_o;
    endtask
    task automatic do_op(nasu_pkg::nasu_op_t op, logic [3:0] imm,
            logic [3:0] m);
        @(posedge clk_i);
        issue_i <= '{1'b1, op, imm, 5'h03};
        mem_rdata_i <= m;
        @(posedge clk_i);
        issue_i.valid <= 1'b0;
        @(negedge clk_i);
    endtask
    // Preset acc and carry, run one op, compare with a local model
    task automatic alu(nasu_pkg::nasu_op_t op, logic [3:0] a, logic c,
            logic [3:0] imm, logic [3:0] m);
        logic [4:0] s;
        logic [3:0] ea, wd;
        logic ec, es, ew;
        ea = a;
        ec = c;
        es = 1'b0;
        ew = 1'b0;
        wd = m;
        s = a + imm;
        case (op)
            nasu_pkg::NASU_ADD_MEMORY: ea = a + m;
            nasu_pkg::NASU_ADD_MEMORY_CARRY: {ec, ea} = a + m + c;
            nasu_pkg::NASU_ADD_IMMEDIATE: {es, ea} = {!s[4], s[3:0]};
            nasu_pkg::NASU_AND_MEMORY: ea = a & m;
            nasu_pkg::NASU_OR_MEMORY: ea = a | m;
            nasu_pkg::NASU_SET_CARRY: ec = 1'b1;
            nasu_pkg::NASU_CLEAR_CARRY: ec = 1'b0;
            nasu_pkg::NASU_SKIP_CARRY_ZERO: es = !c;
            nasu_pkg::NASU_COMPLEMENT_ACC: ea = ~a;
            nasu_pkg::NASU_ROTATE_RIGHT_CARRY: {ea, ec} = {c, a};
            nasu_pkg::NASU_MEMORY_BIT_SET:
                {ew, wd} = {1'b1, m | 4'h1 << imm[1:0]};
            nasu_pkg::NASU_MEMORY_BIT_CLEAR:
                {ew, wd} = {1'b1, m & ~(4'h1 << imm[1:0])};
            nasu_pkg::NASU_MEMORY_BIT_TEST: es = !m[imm[1:0]];
            nasu_pkg::NASU_COMPARE_MEMORY: es = (a == m);
            nasu_pkg::NASU_COMPARE_IMMEDIATE: es = (a == imm);
            default: ;
        endcase
        do_op(nasu_pkg::NASU_NOP, 4'h0, 4'h0);
        reg_acc(1'b1, nasu_pkg::SETUP_OFFSET, {28'h0, a});
        do_op(c ? nasu_pkg::NASU_SET_CARRY : nasu_pkg::NASU_CLEAR_CARRY,
            4'h0, 4'h0);
        do_op(op, imm, m);
        check("alu result", {acc_o, carry_o, skip_o}, {ea, ec, es});
        check("mem write", mem_wr_o.we, ew);
        if (ew) check("mem data", mem_wr_o.wdata, wd);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        check("reset state",
            {busy_o, stack_use_o, acc_o, b_reg_o, ext_reg_o, carry_o, skip_o},
            32'h0);
        reg_acc(1'b0, 4'hC, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            issue_i <= '{1'b1, nasu_pkg::NASU_LOAD_ACC_IMMEDIATE,
                4'(5 + i), 5'h03};
        end
        @(posedge clk_i);
        issue_i.valid <= 1'b0;
        @(negedge clk_i);
        check("load chain acc", acc_o, 4'h5);
        // Chain bit must still stand while no instruction is offered
        reg_acc(1'b0, nasu_pkg::STATUS_OFFSET, 32'h0);
        check("status chain", rd, 32'h0000_8005);
        $display("test load chain done");
        alu(nasu_pkg::NASU_ADD_MEMORY, 4'h9, 1'b1, 4'h0, 4'h8);
        alu(nasu_pkg::NASU_ADD_MEMORY_CARRY, 4'hF, 1'b1, 4'h0, 4'h0);
        alu(nasu_pkg::NASU_ADD_MEMORY_CARRY, 4'h3, 1'b1, 4'h0, 4'h4);
        alu(nasu_pkg::NASU_ADD_IMMEDIATE, 4'hE, 1'b0, 4'h1, 4'h0);
        alu(nasu_pkg::NASU_ADD_IMMEDIATE, 4'hE, 1'b0, 4'h3, 4'h0);
        alu(nasu_pkg::NASU_AND_MEMORY, 4'hC, 1'b0, 4'h0, 4'hA);
        alu(nasu_pkg::NASU_OR_MEMORY, 4'hC, 1'b0, 4'h0, 4'hA);
        alu(nasu_pkg::NASU_COMPLEMENT_ACC, 4'h5, 1'b0, 4'h0, 4'h0);
        alu(nasu_pkg::NASU_COMPARE_MEMORY, 4'h6, 1'b0, 4'h0, 4'h6);
        alu(nasu_pkg::NASU_COMPARE_MEMORY, 4'h6, 1'b0, 4'h0, 4'h7);
        for (int c = 0; c < 2; c++) begin
            alu(nasu_pkg::NASU_SET_CARRY, 4'h3, 1'(c), 4'h0, 4'h0);
            alu(nasu_pkg::NASU_CLEAR_CARRY, 4'h3, 1'(c), 4'h0, 4'h0);
            alu(nasu_pkg::NASU_SKIP_CARRY_ZERO, 4'h3, 1'(c),
                4'h0, 4'h0);
            alu(nasu_pkg::NASU_ROTATE_RIGHT_CARRY, 4'h6 - 4'(5 * c),
                1'(c), 4'h0, 4'h0);
        end
        for (int j = 0; j < 4; j++) begin
            alu(nasu_pkg::NASU_MEMORY_BIT_SET, 4'h0, 1'b0,
                4'(j), 4'h0);
            alu(nasu_pkg::NASU_MEMORY_BIT_CLEAR, 4'h0, 1'b0,
                4'(j), 4'hF);
            alu(nasu_pkg::NASU_MEMORY_BIT_TEST, 4'h0, 1'b0,
                4'(j), 4'h5);
        end
        for (int n = 0; n < 16; n++)
            alu(nasu_pkg::NASU_COMPARE_IMMEDIATE, 4'h7, 1'b0,
                4'(n), 4'h0);
        $display("test arithmetic and skips done");
        // Accumulator still holds 7: arm a skip before the dropped write
        do_op(nasu_pkg::NASU_COMPARE_IMMEDIATE, 4'h7, 4'h0);
        check("skip armed", skip_o, 1'b1);
        do_op(nasu_pkg::NASU_MEMORY_BIT_SET, 4'h0, 4'h0);
        check("skipped write", {mem_wr_o.we, skip_o}, 2'b00);
        do_op(nasu_pkg::NASU_COMPLEMENT_ACC, 4'h0, 4'h0);
        check("after skip", {acc_o, skip_o}, {4'h8, 1'b0});
        $display("test skipped instruction done");
        for (int f = 0; f < 2; f++) begin
            reg_acc(1'b1, nasu_pkg::CTRL_OFFSET, 32'(f));
            reg_acc(1'b0, nasu_pkg::CTRL_OFFSET, 32'h0);
            check("fetch flag", rd, 32'(f));
            do_op(nasu_pkg::NASU_NOP, 4'h0, 4'h0);
            reg_acc(1'b1, nasu_pkg::SETUP_OFFSET, 32'h0000_0509);
            @(posedge clk_i);
            issue_i <= '{1'b1, nasu_pkg::NASU_TABLE_LOOKUP, 4'h0, 5'h03};
            @(posedge clk_i);
            issue_i.valid <= 1'b0;
            // Pattern only in the wait cycle, so a late or early latch fails
            rom_data_i <= f ? 10'h2C7 : 10'h16B;
            @(negedge clk_i);
            check("table request", rom_req_o, {1'b1, 5'h03, 7'h59});
            check("stack busy", {busy_o, stack_use_o}, 2'b11);
            @(posedge clk_i);
            rom_data_i <= 10'h000;
            @(negedge clk_i);
            check("table data", {b_reg_o, acc_o}, f ? 8'hC7 : 8'h6B);
            check("table ext", ext_reg_o, f ? 3'h2 : 3'h5);
            check("stack free", {busy_o, stack_use_o}, 2'b00);
        end
        $display("test table lookup done");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("Error run length expected end seen hang");
        final_report();
    end
endmodule
`default_nettype wire
